// [bench/core_model.sv]
`timescale 1ns/1ps
module core_model (
  // Clock
  input  wire logic        pclk,
  // APB master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Core events
  output logic             halt_exec,
  output logic             ext_irq_wake,
  output logic             osc_irq_wake
);
  initial begin
    {psel, penable, pwrite} = 3'h0;
    {halt_exec, ext_irq_wake, osc_irq_wake} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // The request stays put until the edge that samples pready high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Events last one cycle, as a core instruction or wake line would.
  task automatic pulse(input int which);
    @(posedge pclk);
    case (which)
      0: halt_exec <= 1'b1;
      1: ext_irq_wake <= 1'b1;
      default: osc_irq_wake <= 1'b1;
    endcase
    @(posedge pclk);
    {halt_exec, ext_irq_wake, osc_irq_wake} <= 3'h0;
  endtask
endmodule // core_model

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench;
  import wdg_pkg::*;
  localparam int STEP = 1024;
  localparam int PULSE = 16;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [1:0]  timebase_select = 2'h0;
  logic        timebase_irq_enable = 1'b0;
  logic        halt_reset_option = 1'b0;
  logic        hw_watchdog_option = 1'b0;
  logic        long_startup_sel = 1'b0;
  logic        psel, penable, pwrite, pready, pslverr, wdg_rst_n;
  logic        halt_exec, ext_irq_wake, osc_irq_wake, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          errors = 0;
  int          checks = 0;
  int          msb_t[4] = '{4, 8, 20, 49};
  int          lsb_t[4] = '{59, 53, 35, 54};

  always #2.5 pclk = ~pclk;

  watchdog_timeout_lowpower #(.STEP_CYCLES(STEP),
    .RST_PULSE_CYCLES(PULSE)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timebase_select(timebase_select),
    .timebase_irq_enable(timebase_irq_enable),
    .halt_reset_option(halt_reset_option),
    .hw_watchdog_option(hw_watchdog_option),
    .long_startup_sel(long_startup_sel), .halt_exec(halt_exec),
    .ext_irq_wake(ext_irq_wake), .osc_irq_wake(osc_irq_wake),
    .wdg_rst_n(wdg_rst_n));

  core_model core (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec),
    .ext_irq_wake(ext_irq_wake), .osc_irq_wake(osc_irq_wake));

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, hi, got);
    checks++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic wr(input logic [7:0] d);
    core.apb(1'b1, CTRL_ADDR, {24'h0, d}, rd, err);
  endtask

  task automatic rdchk(string what, logic [11:0] a, logic [31:0] exp);
    core.apb(1'b0, a, 32'h0, rd, err);
    chk(what, exp, rd);
  endtask

  task automatic sys_reset(input logic long_sel);
    @(posedge pclk);
    presetn <= 1'b0;
    long_startup_sel <= long_sel;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    if (!long_sel) repeat (300) @(posedge pclk);
  endtask

  task automatic wait_rst(input int limit, output int n);
    n = 0;
    while (wdg_rst_n !== 1'b0 && n <= limit) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // Step counts truncate, so integer division is exactly what is wanted.
  function automatic int tmo(int c, int n, bit mx);
    int k = 4 * n / msb_t[c];
    int u = STEP / 256;
    int b = mx ? STEP : (lsb_t[c] + 128) * u;
    if (mx ? n <= msb_t[c] / 4 : n < msb_t[c] / 4) return b + STEP * n;
    return b + STEP * (n - k) + (192 + lsb_t[c]) * u * k;
  endfunction

  task automatic t_timeout;
    int n;
    for (int c = 0; c < 4; c++) begin
      sys_reset(1'b0);
      timebase_select <= 2'(c);
      wr(8'hc1);
      wait_rst(2200, n);
      chk_rng("timeout", tmo(c, 1, 0), tmo(c, 1, 1) + 3, n);
    end
  endtask

  task automatic t_sw_reset;
    int n, m;
    sys_reset(1'b0);
    core.apb(1'b0, 12'h0f0, 32'h0, rd, err);
    chk("unmapped error", 32'h1, {31'h0, err});
    rdchk("ctrl reset", CTRL_ADDR, 32'h7f);
    wr(8'h80);
    wait_rst(4, n);
    chk_rng("sw reset delay", 0, 3, n);
    m = 1;
    while (m < 100) begin
      @(posedge pclk);
      if (wdg_rst_n !== 1'b0) break;
      m++;
    end
    chk_rng("pulse length", PULSE, PULSE, m);
  endtask

  task automatic t_activation(input logic hw, act);
    int n;
    hw_watchdog_option <= hw;
    sys_reset(1'b0);
    timebase_select <= 2'h0;
    if (act) wr(8'hff);
    wr(8'h41);
    wait_rst(2200, n);
    if (hw || act) chk_rng("armed", tmo(0, 1, 0), tmo(0, 1, 1) + 3, n);
    else chk_rng("disarmed", 2201, 2201, n);
    hw_watchdog_option <= 1'b0;
  endtask

  task automatic t_active_halt(input int wake);
    sys_reset(1'b0);
    timebase_irq_enable <= 1'b1;
    wr(8'hff);
    core.pulse(0);
    rdchk("mode", STATUS_ADDR, 32'h13);
    repeat (2500) @(posedge pclk);
    rdchk("frozen", CTRL_ADDR, 32'hff);
    chk("no reset", 32'h1, {31'h0, wdg_rst_n});
    core.pulse(wake);
    rdchk("resumed", STATUS_ADDR, 32'h10);
    timebase_irq_enable <= 1'b0;
  endtask

  task automatic t_plain_halt;
    sys_reset(1'b0);
    wr(8'hff);
    core.pulse(0);
    repeat (2500) @(posedge pclk);
    rdchk("one step", CTRL_ADDR, 32'hfe);
    rdchk("halted", STATUS_ADDR, 32'h12);
    chk("no reset", 32'h1, {31'h0, wdg_rst_n});
    core.pulse(1);
    rdchk("restart", STATUS_ADDR, 32'h14);
    repeat (230) @(posedge pclk);
    rdchk("still wait", STATUS_ADDR, 32'h14);
    repeat (30) @(posedge pclk);
    rdchk("running", STATUS_ADDR, 32'h10);
    sys_reset(1'b0);
    rdchk("disabled", CTRL_ADDR, 32'h7f);
  endtask

  task automatic t_halt_reset;
    int n;
    sys_reset(1'b0);
    halt_reset_option <= 1'b1;
    core.pulse(0);
    wait_rst(5, n);
    chk_rng("halt reset", 0, 3, n);
    halt_reset_option <= 1'b0;
  endtask

  task automatic t_long_restart;
    sys_reset(1'b1);
    repeat (3990) @(posedge pclk);
    rdchk("long wait", STATUS_ADDR, 32'h04);
    repeat (150) @(posedge pclk);
    rdchk("long run", STATUS_ADDR, 32'h00);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    t_sw_reset();
    t_timeout();
    t_activation(1'b0, 1'b0);
    t_activation(1'b0, 1'b1);
    t_activation(1'b1, 1'b0);
    t_active_halt(1);
    t_active_halt(2);
    t_plain_halt();
    t_halt_reset();
    t_long_restart();
    test_done();
  end

  // Expected run is about 30000 cycles; this leaves ample margin.
  initial begin
    repeat (80000) @(posedge pclk);
    errors++;
    $display("[ERR] run_length expected done seen timeout");
    test_done();
  end
endmodule // testbench

// [rtl/watchdog_timeout_lowpower.sv]
`timescale 1ns/1ps
module watchdog_timeout_lowpower #(
  parameter int unsigned STEP_CYCLES      = wdg_pkg::STEP_CYCLES_DEF,
  parameter int unsigned RST_PULSE_CYCLES = wdg_pkg::RST_PULSE_CYC
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Clock controller settings
  input  wire logic [1:0]  timebase_select,
  input  wire logic        timebase_irq_enable,
  // Static options
  input  wire logic        halt_reset_option,
  input  wire logic        hw_watchdog_option,
  input  wire logic        long_startup_sel,
  // Core events
  input  wire logic        halt_exec,
  input  wire logic        ext_irq_wake,
  input  wire logic        osc_irq_wake,
  // Reset request
  output logic             wdg_rst_n
);
  import wdg_pkg::*;

  // All event and setting inputs come from logic on pclk, so none of them
  // passes a synchroniser.

  logic        active_ff;
  logic [6:0]  count_ff;
  wdg_mode_e   mode_ff;
  wdg_mode_e   nxt_mode;
  logic [12:0] delay_ff;
  logic [15:0] pulse_ff;
  logic        wdg_rst_n_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        tick;

  // Bus decode.
  wire logic access   = psel && penable;
  wire logic hit_ctrl = (paddr == CTRL_ADDR);
  wire logic hit_stat = (paddr == STATUS_ADDR);
  wire logic mapped   = hit_ctrl || hit_stat;
  wire logic complete = access && pready_ff;
  wire logic ctrl_wr  = complete && pwrite && hit_ctrl;

  // Timebase constants.
  wire logic [5:0] tb_msb = TB_MSB_TBL[timebase_select*TB_W +: TB_W];
  wire logic [5:0] tb_lsb = TB_LSB_TBL[timebase_select*TB_W +: TB_W];

  // The option byte overrides the activation bit.
  wire logic wdg_on = active_ff || hw_watchdog_option;

  // Timeout count is the six low bits; bit 6 only marks expiry.
  wire logic [5:0] timeout_count     = count_ff[TOP_BIT-1:0];
  wire logic       countdown_top_bit = count_ff[TOP_BIT];

  // Slow and wait are not inputs at all: nothing but a halt, a wake or a
  // reset ever stops the count.
  wire logic run_mode = (mode_ff == MODE_RUN);
  wire logic dec      = (run_mode && tick) || (mode_ff == MODE_HALT_STEP);

  // A static input picks the restart delay.
  wire logic [12:0] delay_lim  = long_startup_sel ? DELAY_LONG : DELAY_SHORT;
  wire logic        delay_done = (delay_ff == delay_lim - 13'h0001);
  wire logic        resume     = (mode_ff == MODE_RESTART) && delay_done;

  wire logic pulse_busy = (pulse_ff != 16'h0000);

  // Rollover out of 40h while counting.
  wire logic roll_rst = wdg_on && run_mode && tick && (count_ff == ROLL_VALUE);
  // Writing the top bit as zero with the watchdog on forces a reset.
  wire logic sw_rst   = ctrl_wr && !pwdata[TOP_BIT] &&
                        (wdg_on || pwdata[ACT_BIT]);
  wire logic halt_rst = halt_exec && run_mode && !timebase_irq_enable &&
                        halt_reset_option;
  wire logic fire     = (roll_rst || sw_rst || halt_rst) && !pulse_busy;

  wire logic [6:0] nxt_count =
    ctrl_wr ? pwdata[TOP_BIT:0] :
    dec     ? count_ff - 7'h01  : count_ff;
  wire logic nxt_active = active_ff || (ctrl_wr && pwdata[ACT_BIT]);

  wire logic [31:0] rd_ctrl = {24'h000000, active_ff, count_ff};
  wire logic [31:0] rd_stat = {27'h0000000, wdg_on, pulse_busy, mode_ff};
  wire logic [31:0] rd_mux  = hit_ctrl ? rd_ctrl : hit_stat ? rd_stat : '0;

  wdg_step_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_step (
    .pclk    (pclk),
    .presetn (presetn),
    .restart (ctrl_wr),
    .resume  (resume),
    .run     (run_mode),
    .msb     (tb_msb),
    .lsb     (tb_lsb),
    .tick    (tick)
  );

  // Mode sequencing around halt.
  always_comb begin
    nxt_mode = mode_ff;
    unique case (mode_ff)
      MODE_RUN: begin
        if (halt_exec && timebase_irq_enable) begin
          nxt_mode = MODE_ACTIVE_HALT;
        end else if (halt_exec && !halt_reset_option) begin
          nxt_mode = MODE_HALT_STEP;
        end
      end
      MODE_HALT_STEP: begin
        nxt_mode = MODE_HALTED;
      end
      MODE_HALTED: begin
        if (ext_irq_wake) begin
          nxt_mode = MODE_RESTART;
        end
      end
      MODE_ACTIVE_HALT: begin
        if (ext_irq_wake || osc_irq_wake) begin
          nxt_mode = MODE_RUN;
        end
      end
      MODE_RESTART: begin
        if (delay_done) begin
          nxt_mode = MODE_RUN;
        end
      end
    endcase
  end

  // Reset leaves the activation bit clear and waits out the start-up delay,
  // which covers leaving either halt through a reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_ff  <= MODE_RESTART;
      delay_ff <= '0;
    end else begin
      mode_ff  <= nxt_mode;
      delay_ff <= (mode_ff == MODE_RESTART) ? delay_ff + 13'h0001 : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_ff <= CTRL_RESET[ACT_BIT];
      count_ff  <= CTRL_RESET[TOP_BIT:0];
    end else begin
      active_ff <= nxt_active;
      count_ff  <= nxt_count;
    end
  end

  // The pulse is a request to the reset controller; the block itself only
  // returns to its reset state when presetn comes back.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_ff     <= '0;
      wdg_rst_n_ff <= 1'b1;
    end else if (fire) begin
      pulse_ff     <= 16'(RST_PULSE_CYCLES);
      wdg_rst_n_ff <= 1'b0;
    end else begin
      pulse_ff     <= pulse_busy ? pulse_ff - 16'h0001 : pulse_ff;
      wdg_rst_n_ff <= !(pulse_ff > 16'h0001);
    end
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      pready_ff  <= access && !pready_ff;
      pslverr_ff <= access && !pready_ff && !mapped;
      prdata_ff  <= (access && !pready_ff && !pwrite) ? rd_mux : '0;
    end
  end

  assign prdata    = prdata_ff;
  assign pready    = pready_ff;
  assign pslverr   = pslverr_ff;
  assign wdg_rst_n = wdg_rst_n_ff;

  a_tb_table:
    assert property (@(posedge pclk) disable iff (!presetn)
    timebase_select == 2'h2 |-> tb_msb == 6'h14 && tb_lsb == 6'h23)
    else $error("timebase table entry wrong");

  a_count_six:
    assert property (@(posedge pclk) disable iff (!presetn)
    run_mode && tick && !ctrl_wr && timeout_count == 6'h00
    |=> countdown_top_bit != $past(countdown_top_bit))
    else $error("top bit did not follow the six low bits");

  a_roll_reset:
    assert property (@(posedge pclk) disable iff (!presetn)
    roll_rst && !pulse_busy && !ctrl_wr
    |=> !wdg_rst_n && count_ff == 7'h3f)
    else $error("rollover did not start a reset");

  a_pulse_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
    $fell(wdg_rst_n) |-> !wdg_rst_n [*8])
    else $error("reset pulse too short");

  a_halt_once:
    assert property (@(posedge pclk) disable iff (!presetn)
    run_mode && halt_exec && !timebase_irq_enable && !halt_reset_option
    && !ctrl_wr |=> ##1 count_ff == $past(count_ff, 2) - 7'h01
    && mode_ff == MODE_HALTED)
    else $error("plain halt did not decrement exactly once");

  a_halted_still:
    assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff == MODE_HALTED && !ctrl_wr |=> $stable(count_ff)
    && !$fell(wdg_rst_n))
    else $error("counter moved or reset fired in halt");

  a_halt_reset:
    assert property (@(posedge pclk) disable iff (!presetn)
    halt_rst && !pulse_busy |=> !wdg_rst_n && mode_ff == MODE_RUN)
    else $error("halt with reset option gave no reset");

  a_active_freeze:
    assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff == MODE_ACTIVE_HALT && !ctrl_wr |=> $stable(count_ff))
    else $error("counter moved in active halt");

  a_active_wake:
    assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff == MODE_ACTIVE_HALT && (ext_irq_wake || osc_irq_wake)
    |=> run_mode)
    else $error("active halt wake was delayed");

  a_restart_wait:
    assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff == MODE_HALTED && ext_irq_wake && !long_startup_sel
    |=> (mode_ff == MODE_RESTART) [*8])
    else $error("restart after halt came too early");

  a_restart_len:
    assert property (@(posedge pclk) disable iff (!presetn)
    $past(mode_ff) == MODE_RESTART && run_mode
    |-> $past(delay_ff) == $past(delay_lim) - 13'h0001)
    else $error("restart delay has wrong length");

  a_active_sticky:
    assert property (@(posedge pclk) disable iff (!presetn)
    active_ff |=> active_ff)
    else $error("activation bit cleared without reset");

  a_tb_code0:
    assert property (@(posedge pclk) disable iff (!presetn)
    timebase_select == 2'h0 |-> tb_msb == 6'h04 && tb_lsb == 6'h3b)
    else $error("timebase table entry zero wrong");

  a_run_counts:
    assert property (@(posedge pclk) disable iff (!presetn)
    run_mode && tick && !ctrl_wr |=> count_ff == $past(count_ff) - 7'h01)
    else $error("counter missed a step while running");

  a_off_quiet:
    assert property (@(posedge pclk) disable iff (!presetn)
    !wdg_on && !ctrl_wr && !halt_exec && !pulse_busy |=> wdg_rst_n)
    else $error("disabled watchdog requested a reset");

  a_hw_roll:
    assert property (@(posedge pclk) disable iff (!presetn)
    hw_watchdog_option && run_mode && tick && count_ff == ROLL_VALUE
    && !ctrl_wr && !pulse_busy |=> !wdg_rst_n)
    else $error("hardware option rollover gave no reset");

  a_restart_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff == MODE_RESTART && !ctrl_wr |=> $stable(count_ff))
    else $error("counter moved during the restart delay");

  a_active_quiet:
    assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff == MODE_ACTIVE_HALT && !ctrl_wr && !pulse_busy |=> wdg_rst_n)
    else $error("reset requested in active halt");

  a_active_enter:
    assert property (@(posedge pclk) disable iff (!presetn)
    run_mode && halt_exec && timebase_irq_enable
    |=> mode_ff == MODE_ACTIVE_HALT)
    else $error("halt with interrupt enable missed active halt");

endmodule // watchdog_timeout_lowpower

// [rtl/wdg_pkg.sv]
package wdg_pkg;

  // Oscillator clock of the block.
  localparam int unsigned CLK_PERIOD_NS = 5;

  // Register map: printed indices, byte address is four times the index.
  localparam int unsigned CTRL_IDX      = 'h2a;
  localparam int unsigned STATUS_IDX    = 'h2b;
  localparam logic [11:0] CTRL_ADDR     = 12'(CTRL_IDX * 4);
  localparam logic [11:0] STATUS_ADDR   = 12'(STATUS_IDX * 4);
  localparam logic [7:0]  CTRL_RESET    = 8'h7f;
  localparam int unsigned ACT_BIT       = 7;
  localparam int unsigned TOP_BIT       = 6;
  localparam logic [6:0]  ROLL_VALUE    = 7'h40;

  // Status register fields.
  localparam int unsigned ST_MODE_LSB   = 0;
  localparam int unsigned ST_PULSE_BIT  = 3;
  localparam int unsigned ST_ON_BIT     = 4;

  // Timebase tables, one 6-bit entry per select code, code 0 lowest.
  localparam logic [23:0] TB_MSB_TBL    = {6'h31, 6'h14, 6'h08, 6'h04};
  localparam logic [23:0] TB_LSB_TBL    = {6'h36, 6'h23, 6'h35, 6'h3b};
  localparam int unsigned TB_W          = 6;

  // Step timing: full step in clocks, step bases in units of one 256th of a full step.
  localparam int unsigned STEP_CYCLES_DEF = 16384;
  localparam int unsigned SUB_DIV         = 256;
  localparam logic [7:0]  FIRST_MIN_BASE  = 8'h80;
  localparam logic [7:0]  SHORT_BASE      = 8'hc0;
  localparam logic [5:0]  ACC_STEP        = 6'h04;

  // Restart delay after leaving a halt, in clocks.
  localparam logic [12:0] DELAY_SHORT   = 13'h0100;
  localparam logic [12:0] DELAY_LONG    = 13'h1000;

  // Reset pulse length.
  localparam int unsigned RST_PULSE_NS  = 30000;
  localparam int unsigned RST_PULSE_CYC = RST_PULSE_NS / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    MODE_RUN,
    MODE_HALT_STEP,
    MODE_HALTED,
    MODE_ACTIVE_HALT,
    MODE_RESTART
  } wdg_mode_e;

endpackage

// [rtl/wdg_step_timer.sv]
`timescale 1ns/1ps
module wdg_step_timer #(
  parameter int unsigned STEP_CYCLES = wdg_pkg::STEP_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       restart,
  input  wire logic       resume,
  input  wire logic       run,
  // Timebase constants
  input  wire logic [5:0] msb,
  input  wire logic [5:0] lsb,
  // Decrement strobe
  output logic            tick
);
  import wdg_pkg::*;

  localparam int unsigned W      = 17;
  localparam logic [W-1:0] STEP_W = W'(STEP_CYCLES);
  localparam logic [W-1:0] SUB_W  = W'(STEP_CYCLES / SUB_DIV);
  localparam logic [W-1:0] ONE_W  = W'(1);

  logic [W-1:0] phase_ff;
  logic [W-1:0] remain_ff;
  logic [5:0]   acc_ff;
  logic         tick_ff;

  wire logic [W-1:0] first_min = (W'(lsb) + W'(FIRST_MIN_BASE)) * SUB_W;
  wire logic [W-1:0] short_len = (W'(lsb) + W'(SHORT_BASE)) * SUB_W;
  // The prescaler phase at the write is unknown to software, so the first
  // step is whatever remains of it, but never below the minimum.
  wire logic [W-1:0] phase_left = STEP_W - phase_ff;
  wire logic [W-1:0] first_len  =
    (phase_left < first_min) ? first_min : phase_left;
  // Floor of 4*k/MSB advances exactly when the accumulator wraps.
  wire logic [5:0] acc_sum  = acc_ff + ACC_STEP;
  wire logic       is_short = (acc_sum >= msb);
  wire logic [5:0] nxt_acc  = is_short ? acc_sum - msb : acc_sum;
  wire logic       step_end = run && (remain_ff == ONE_W);
  wire logic [W-1:0] nxt_phase =
    (phase_ff == STEP_W - ONE_W) ? '0 : phase_ff + ONE_W;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= '0;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain_ff <= STEP_W;
      acc_ff    <= '0;
      tick_ff   <= 1'b0;
    end else if (restart) begin
      remain_ff <= first_len;
      acc_ff    <= '0;
      tick_ff   <= 1'b0;
    end else if (resume) begin
      remain_ff <= STEP_W;
      tick_ff   <= 1'b0;
    end else if (step_end) begin
      remain_ff <= is_short ? short_len : STEP_W;
      acc_ff    <= nxt_acc;
      tick_ff   <= 1'b1;
    end else begin
      remain_ff <= run ? remain_ff - ONE_W : remain_ff;
      tick_ff   <= 1'b0;
    end
  end

  assign tick = tick_ff;

  a_first_bounds:
    assert property (@(posedge pclk) disable iff (!presetn)
    restart |=> remain_ff >= $past(first_min)
    && remain_ff <= STEP_W)
    else $error("first step outside its window");

  a_short_step:
    assert property (@(posedge pclk) disable iff (!presetn)
    step_end && !restart && !resume && is_short
    |=> remain_ff == $past(short_len) && tick)
    else $error("shortened step has wrong length");

  a_full_step:
    assert property (@(posedge pclk) disable iff (!presetn)
    step_end && !restart && !resume && !is_short
    |=> remain_ff == STEP_W)
    else $error("full step has wrong length");

endmodule // wdg_step_timer
